// ==== hdl/acs_pkg.sv ====
package acs_pkg;

   // ************************************************************
   // Operating mode codes
   // ************************************************************
   localparam logic [2:0] MODE_CONVERT = 3'h0;
   localparam logic [2:0] MODE_SELF_CAL = 3'h1;
   localparam logic [2:0] MODE_SYS_OFFSET = 3'h2;
   localparam logic [2:0] MODE_SYS_POS_FS = 3'h3;
   localparam logic [2:0] MODE_SYS_NEG_FS = 3'h4;
   localparam logic [2:0] MODE_SYS_OFS_INT = 3'h5;
   localparam logic [2:0] MODE_SYS_GAIN = 3'h6;
   localparam logic [2:0] MODE_RESERVED = 3'h7;

   // ************************************************************
   // Register map (word byte addresses)
   // ************************************************************
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_OFFSET = 4'h4;
   localparam logic [3:0] ADDR_POS_FS = 4'h8;
   localparam logic [3:0] ADDR_NEG_FS = 4'hc;
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int ADDR_DATA_BIT = 4;

   // Control fields
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_NOTCH_LSB = 8;
   localparam int CTL_GAIN_LSB = 20;

   // ************************************************************
   // Reset values and timing
   // ************************************************************
   localparam logic [23:0] OFFSET_RESET = 24'h000000;
   localparam logic [23:0] FS_RESET = 24'h800000;
   localparam logic [10:0] NOTCH_RESET = 11'h00a;
   localparam int NOTCH_DIV = 512;
   localparam logic [2:0] STEP_SETTLE = 3'h3;
   localparam logic [2:0] STEP_SYSTEM = 3'h4;
   localparam logic [2:0] STEP_ONE = 3'h1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [3:0] {
      SEQ_IDLE, SEQ_CONV_WAIT, SEQ_OFFSET, SEQ_POS, SEQ_NEG,
      SEQ_FINAL, SEQ_RUN
   } acs_seq_t;

   typedef struct packed {
      logic [2:0] mode;
      logic [10:0] notch;
      logic [2:0] gain;
   } acs_ctl_t;

endpackage : acs_pkg

// ==== hdl/acs_sequencer.sv ====
`timescale 1ns/1ps
module acs_sequencer #(
   parameter int NOTCH_W = 11
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [4:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Converter datapath
   input wire logic [23:0] i_raw_sample,
   output logic [23:0] o_result,
   output logic o_conversion_done_n,
   // Analog switch controls
   output logic o_short_inputs,
   output logic o_ref_apply,
   output logic o_ref_invert,
   output logic o_input_invert
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      acs_pkg::acs_ctl_t ctl;
      logic [23:0] offset;
      logic [23:0] pos_fs;
      logic [23:0] neg_fs;
      logic [23:0] result;
      logic [31:0] rdata;
      logic wait_n;
      logic [19:0] div_cnt;
      logic [2:0] step_cnt;
      acs_pkg::acs_seq_t seq;
      logic done_n;
      logic short_in;
      logic ref_on;
      logic ref_inv;
      logic in_inv;
   } acs_state_t;

   acs_state_t st;
   acs_state_t next_st;
   logic period_tick;
   logic [19:0] period_len;

   // Corrected output: offset removal, slope from the matching FS coefficient
   function automatic logic [23:0] acs_correct(input logic [23:0] raw,
      input logic [23:0] ofs, input logic [23:0] pfs,
      input logic [23:0] nfs);
      logic signed [25:0] diff;
      logic [47:0] prod;
      logic [23:0] slope;
      diff = $signed({2'h0, raw}) - $signed({2'h0, ofs});
      slope = diff[25] ? nfs : pfs;
      prod = 48'(diff[25] ? -diff : diff) * 48'(slope);
      if (diff[25])
         acs_correct = 24'(24'h800000 - prod[46:23]);
      else
         acs_correct = 24'(24'h800000 + prod[46:23]);
   endfunction

   // True on the period tick that ends a step (step count at 1)
   function automatic logic step_end(input logic [2:0] cnt,
      input logic tick);
      step_end = tick && (cnt == 3'h1);
   endfunction

   // ************************************************************
   // Conversion period divider
   // ************************************************************
   assign period_len = 20'(acs_pkg::NOTCH_DIV) * 20'(st.ctl.notch);
   assign period_tick = (st.div_cnt == period_len - 20'h1);

   always_comb
   begin
      next_st = st;
      next_st.wait_n = 1'b0;
      if (period_tick)
         next_st.div_cnt = 20'h0;
      else
         next_st.div_cnt = st.div_cnt + 20'h1;
      if (period_tick && st.step_cnt != 3'h0)
         next_st.step_cnt = st.step_cnt - 3'h1;

      // Conversion result stream, corrected each period
      if (period_tick && st.seq == acs_pkg::SEQ_RUN)
         next_st.result = acs_correct(i_raw_sample, st.offset, st.pos_fs,
            st.neg_fs);

      // Sequencer
      unique case (st.seq)
         acs_pkg::SEQ_IDLE:
         begin
            next_st.seq = acs_pkg::SEQ_CONV_WAIT;
            next_st.step_cnt = acs_pkg::STEP_SETTLE;
         end
         acs_pkg::SEQ_CONV_WAIT:
            if (step_end(st.step_cnt, period_tick))
            begin
               next_st.seq = acs_pkg::SEQ_RUN;
               next_st.done_n = 1'b0;
               next_st.result = acs_correct(i_raw_sample, st.offset,
                  st.pos_fs, st.neg_fs);
            end
         acs_pkg::SEQ_OFFSET:
            if (step_end(st.step_cnt, period_tick))
            begin
               next_st.offset = i_raw_sample;
               next_st.short_in = 1'b0;
               if (st.ctl.mode == acs_pkg::MODE_SYS_OFFSET)
               begin
                  next_st.seq = acs_pkg::SEQ_RUN;
                  next_st.done_n = 1'b0;
               end
               else
               begin
                  next_st.seq = acs_pkg::SEQ_POS;
                  next_st.ref_on = 1'b1;
                  next_st.step_cnt = acs_pkg::STEP_SETTLE;
               end
            end
         acs_pkg::SEQ_POS:
            if (step_end(st.step_cnt, period_tick))
            begin
               next_st.pos_fs = i_raw_sample;
               next_st.in_inv = 1'b0;
               if (st.ctl.mode == acs_pkg::MODE_SYS_GAIN ||
                  st.ctl.mode == acs_pkg::MODE_SYS_POS_FS)
               begin
                  next_st.seq = acs_pkg::SEQ_RUN;
                  next_st.done_n = 1'b0;
               end
               else
               begin
                  next_st.seq = acs_pkg::SEQ_NEG;
                  next_st.ref_inv = 1'b1;
                  next_st.step_cnt = acs_pkg::STEP_SETTLE;
               end
            end
         acs_pkg::SEQ_NEG:
            if (step_end(st.step_cnt, period_tick))
            begin
               next_st.neg_fs = i_raw_sample;
               if (st.ctl.mode == acs_pkg::MODE_SYS_NEG_FS)
               begin
                  next_st.seq = acs_pkg::SEQ_RUN;
                  next_st.done_n = 1'b0;
               end
               else if (st.ctl.mode == acs_pkg::MODE_SYS_GAIN)
               begin
                  next_st.seq = acs_pkg::SEQ_POS;
                  next_st.in_inv = 1'b1;
                  next_st.step_cnt = acs_pkg::STEP_ONE;
               end
               else
               begin
                  next_st.seq = acs_pkg::SEQ_FINAL;
                  next_st.ref_on = 1'b0;
                  next_st.ref_inv = 1'b0;
                  next_st.step_cnt = acs_pkg::STEP_SETTLE;
               end
            end
         acs_pkg::SEQ_FINAL:
            if (step_end(st.step_cnt, period_tick))
            begin
               next_st.seq = acs_pkg::SEQ_RUN;
               next_st.done_n = 1'b0;
            end
         acs_pkg::SEQ_RUN:
            ;
         default:
            next_st.seq = acs_pkg::SEQ_IDLE;
      endcase

      // ************************************************************
      // Avalon-MM slave, one wait state per access
      // ************************************************************
      if ((i_read || i_write) && !st.wait_n)
      begin
         next_st.wait_n = 1'b1;
         next_st.rdata = 32'h0;
         if (i_read)
         begin
            if (i_address[acs_pkg::ADDR_DATA_BIT])
               unique case (i_address[3:0])
                  acs_pkg::ADDR_DATA:
                     next_st.rdata = {8'h0, st.result};
                  acs_pkg::ADDR_STATUS:
                     next_st.rdata = {20'h0, 4'(st.seq), 7'h0, st.done_n};
                  default:
                     next_st.rdata = 32'h0;
               endcase
            else
               unique case (i_address[3:0])
                  acs_pkg::ADDR_CONTROL:
                     next_st.rdata = {9'h0, st.ctl.gain, 1'h0, st.ctl.notch,
                        5'h0, st.ctl.mode};
                  acs_pkg::ADDR_OFFSET:
                     next_st.rdata = {8'h0, st.offset};
                  acs_pkg::ADDR_POS_FS:
                     next_st.rdata = {8'h0, st.pos_fs};
                  acs_pkg::ADDR_NEG_FS:
                     next_st.rdata = {8'h0, st.neg_fs};
                  default:
                     next_st.rdata = 32'h0;
               endcase
         end
         else if (!i_address[acs_pkg::ADDR_DATA_BIT])
            unique case (i_address[3:0])
               acs_pkg::ADDR_CONTROL:
               begin
                  next_st.ctl.mode = i_writedata[acs_pkg::CTL_MODE_LSB +: 3];
                  next_st.ctl.notch =
                     i_writedata[acs_pkg::CTL_NOTCH_LSB +: 11];
                  next_st.ctl.gain = i_writedata[acs_pkg::CTL_GAIN_LSB +: 3];
                  // Restart the selected sequence
                  next_st.done_n = 1'b1;
                  next_st.div_cnt = 20'h0;
                  next_st.short_in = 1'b0;
                  next_st.ref_on = 1'b0;
                  next_st.ref_inv = 1'b0;
                  next_st.in_inv = 1'b0;
                  unique case (i_writedata[acs_pkg::CTL_MODE_LSB +: 3])
                     acs_pkg::MODE_CONVERT:
                     begin
                        next_st.seq = acs_pkg::SEQ_CONV_WAIT;
                        next_st.step_cnt = acs_pkg::STEP_SETTLE;
                     end
                     acs_pkg::MODE_SELF_CAL:
                     begin
                        next_st.seq = acs_pkg::SEQ_OFFSET;
                        next_st.short_in = 1'b1;
                        next_st.step_cnt = acs_pkg::STEP_SETTLE;
                     end
                     acs_pkg::MODE_SYS_OFFSET:
                     begin
                        next_st.seq = acs_pkg::SEQ_OFFSET;
                        next_st.step_cnt = acs_pkg::STEP_SYSTEM;
                     end
                     acs_pkg::MODE_SYS_POS_FS:
                     begin
                        next_st.seq = acs_pkg::SEQ_POS;
                        next_st.step_cnt = acs_pkg::STEP_SYSTEM;
                     end
                     acs_pkg::MODE_SYS_NEG_FS:
                     begin
                        next_st.seq = acs_pkg::SEQ_NEG;
                        next_st.step_cnt = acs_pkg::STEP_SYSTEM;
                     end
                     acs_pkg::MODE_SYS_OFS_INT:
                     begin
                        next_st.seq = acs_pkg::SEQ_OFFSET;
                        next_st.step_cnt = acs_pkg::STEP_SETTLE;
                     end
                     acs_pkg::MODE_SYS_GAIN:
                     begin
                        next_st.seq = acs_pkg::SEQ_NEG;
                        next_st.step_cnt = acs_pkg::STEP_SETTLE;
                     end
                     acs_pkg::MODE_RESERVED:
                        // Undefined selection: parked in IDLE until a new mode or another register is written
                        next_st.seq = acs_pkg::SEQ_IDLE;
                  endcase
               end
               acs_pkg::ADDR_OFFSET:
                  next_st.offset = i_writedata[23:0];
               acs_pkg::ADDR_POS_FS:
                  next_st.pos_fs = i_writedata[23:0];
               acs_pkg::ADDR_NEG_FS:
                  next_st.neg_fs = i_writedata[23:0];
               default:
                  ;
            endcase
      end
      // Reserved mode stays parked in IDLE except in a bus write cycle, which lets it restart
      if (st.ctl.mode == acs_pkg::MODE_RESERVED &&
         st.seq == acs_pkg::SEQ_IDLE && next_st.seq != acs_pkg::SEQ_IDLE &&
         !(i_write && !st.wait_n))
         next_st.seq = acs_pkg::SEQ_IDLE;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         st <= '0;
         st.ctl.notch <= acs_pkg::NOTCH_RESET;
         st.offset <= acs_pkg::OFFSET_RESET;
         st.pos_fs <= acs_pkg::FS_RESET;
         st.neg_fs <= acs_pkg::FS_RESET;
         st.result <= 24'h800000;
         st.done_n <= 1'b1;
         st.seq <= acs_pkg::SEQ_IDLE;
      end
      else
         st <= next_st;
   end

   assign o_readdata = st.rdata;
   assign o_waitrequest = !st.wait_n;
   assign o_result = st.result;
   assign o_conversion_done_n = st.done_n;
   assign o_short_inputs = st.short_in;
   assign o_ref_apply = st.ref_on;
   assign o_ref_invert = st.ref_inv;
   assign o_input_invert = st.in_inv;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence mode_write_s;
      i_write && !st.wait_n && i_address == 5'h00;
   endsequence

   done_after_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      mode_write_s |=> o_conversion_done_n)
      else $error("data-ready low right after mode write");
   offset_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      st.seq == acs_pkg::SEQ_RUN && !(i_write && !st.wait_n)
      |=> $stable(st.offset) && $stable(st.pos_fs))
      else $error("coefficient changed in conversion");
   short_self_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_short_inputs |-> st.seq == acs_pkg::SEQ_OFFSET)
      else $error("inputs shorted outside offset step");
   ref_pos_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_ref_invert |-> o_ref_apply)
      else $error("reference reversed while not applied");
   tick_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      period_tick |=> st.div_cnt == 20'h0)
      else $error("period divider not restarted");
   done_in_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_conversion_done_n |-> st.seq == acs_pkg::SEQ_RUN)
      else $error("data-ready low before sequence end");
   gain_neg_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_input_invert |-> st.seq == acs_pkg::SEQ_POS &&
      st.ctl.mode == acs_pkg::MODE_SYS_GAIN)
      else $error("input inverted outside gain step");
   wait_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("bus answer not after one wait cycle");

endmodule // acs_sequencer

// ==== sim/acs_host.sv ====
`timescale 1ns/1ps
module acs_host #(
   parameter logic [2:0] GAIN_ONE = 3'h0
) (
   // Clock
   input wire logic i_clk,
   // Avalon-MM master
   input wire logic [31:0] i_readdata,
   input wire logic i_waitrequest,
   output logic [4:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   // Settled analog input, seen as a converted word
   output logic [23:0] o_raw_sample
);
   initial
   begin
      o_address = 5'h00;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h00000000;
      o_raw_sample = 24'h000000;
   end

   // ************************************************************
   // Bus cycle
   // ************************************************************
   task automatic bus_xfer(input logic wr, input logic [4:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata,
      output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      rdata = 32'h00000000;
      @(posedge i_clk);
      o_address <= addr;
      o_write <= wr;
      o_read <= !wr;
      o_writedata <= wdata;
      // Request holds until the edge that sees waitrequest low
      while (n < 64 && !ok)
      begin
         @(posedge i_clk);
         ok = !i_waitrequest;
         rdata = i_readdata;
         n++;
      end
      o_read <= 1'b0;
      o_write <= 1'b0;
      // Released lines do not keep the last value
      o_address <= ~addr;
      o_writedata <= ~wdata;
   endtask

   // Input is applied and settled before run_mode selects a mode
   task automatic set_input(input logic [23:0] v);
      @(posedge i_clk);
      o_raw_sample <= v;
      repeat (4) @(posedge i_clk);
   endtask

   // Gain kept at one, notch code 1 for short periods
   function automatic logic [31:0] ctl_word(input logic [2:0] m);
      return (32'(GAIN_ONE) << acs_pkg::CTL_GAIN_LSB)
         | (32'h1 << acs_pkg::CTL_NOTCH_LSB)
         | 32'(m);
   endfunction
endmodule // acs_host

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
      end \
   end
module testbench;
   localparam int PER = 512;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [4:0] address;
   logic rd_en;
   logic wr_en;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic waitreq;
   logic [23:0] raw_in;
   logic [23:0] o_result;
   logic o_conversion_done_n;
   logic o_short_inputs;
   logic o_ref_apply;
   logic o_ref_invert;
   logic o_input_invert;
   int error_cnt = 0;
   int checks = 0;
   logic ok;

   always #12.5 i_clk = ~i_clk;

   acs_sequencer i_acs_sequencer (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_address(address), .i_read(rd_en), .i_write(wr_en),
      .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
      .i_raw_sample(raw_in), .o_result(o_result),
      .o_conversion_done_n(o_conversion_done_n),
      .o_short_inputs(o_short_inputs), .o_ref_apply(o_ref_apply),
      .o_ref_invert(o_ref_invert), .o_input_invert(o_input_invert));

   acs_host host (.i_clk(i_clk), .i_readdata(rdata), .i_waitrequest(waitreq),
      .o_address(address), .o_read(rd_en), .o_write(wr_en),
      .o_writedata(wdata), .o_raw_sample(raw_in));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic end_sim();
      $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      host.bus_xfer(1'b0, a, 32'h00000000, d, ok);
      if (!ok)
      begin
         error_cnt++;
         end_sim();
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      host.bus_xfer(1'b1, a, d, dummy, ok);
      if (!ok)
      begin
         error_cnt++;
         end_sim();
      end
   endtask

   function automatic int periods(input logic [2:0] m);
      case (m)
         acs_pkg::MODE_CONVERT: return 3;
         acs_pkg::MODE_SELF_CAL, acs_pkg::MODE_SYS_OFS_INT: return 12;
         acs_pkg::MODE_RESERVED: return 0;
         default: return 4;
      endcase
   endfunction

   // Switch levels {short, ref, ref invert, input invert} half a period into each step
   function automatic logic [3:0] exp_sw(input logic [2:0] m, input int idx);
      case (m)
         acs_pkg::MODE_SELF_CAL:
            return (idx == 0) ? 4'h8 : (idx == 1) ? 4'h4 :
               (idx == 2) ? 4'h6 : 4'h0;
         acs_pkg::MODE_SYS_OFS_INT:
            return (idx == 1) ? 4'h4 : (idx == 2) ? 4'h6 : 4'h0;
         acs_pkg::MODE_SYS_GAIN: return (idx == 1) ? 4'h1 : 4'h0;
         default: return 4'h0;
      endcase
   endfunction

   function automatic logic near(input logic [23:0] a, input logic [23:0] b);
      return ((a > b) ? a - b : b - a) <= 24'h000002;
   endfunction

   task automatic run_mode(input logic [2:0] m, input logic [23:0] v);
      int k;
      int lim;
      logic [3:0] s;
      k = 0;
      lim = (m == acs_pkg::MODE_RESERVED) ? 5 * PER : periods(m) * PER + 8;
      host.set_input(v);
      wr_reg(5'h00, host.ctl_word(m));
      do
      begin
         @(negedge i_clk);
         k++;
         s = {o_short_inputs, o_ref_apply, o_ref_invert, o_input_invert};
         if (k == 1)
            `CHK("done_n after write", 1'b1, o_conversion_done_n)
         if (o_conversion_done_n === 1'b1 && k % (3 * PER) == PER / 2)
            `CHK("switches", exp_sw(m, k / (3 * PER)), s)
      end
      while (k < lim && o_conversion_done_n !== 1'b0);
      if (m == acs_pkg::MODE_RESERVED)
         `CHK("reserved park", 1'b1, o_conversion_done_n)
      else
      begin
         `CHK("latency ok", 1'b1, k >= lim - 12 && k <= lim - 4)
         if (k >= lim)
            end_sim();
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      logic [31:0] c [3];
      logic [31:0] d;
      logic [23:0] raw;
      void'($urandom(32'h9cf8c17e));
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_reg({1'b0, acs_pkg::ADDR_OFFSET}, d);
      `CHK("offset reset", {8'h00, acs_pkg::OFFSET_RESET}, d)
      rd_reg({1'b0, acs_pkg::ADDR_POS_FS}, d);
      `CHK("pos fs reset", {8'h00, acs_pkg::FS_RESET}, d)
      rd_reg({1'b0, acs_pkg::ADDR_NEG_FS}, d);
      `CHK("neg fs reset", {8'h00, acs_pkg::FS_RESET}, d)
      rd_reg(5'h18, d);
      `CHK("unmapped read", 32'h00000000, d)
      run_mode(acs_pkg::MODE_CONVERT, 24'h001234);
      `CHK("uncorrected", 1'b1, near(o_result, 24'h801234))
      rd_reg(5'h10, d);
      `CHK("data reg", 1'b1, near(d[23:0], 24'h801234))
      rd_reg(5'h00, d);
      `CHK("control reg", 32'h00000100, d)
      rd_reg({1'b1, acs_pkg::ADDR_STATUS}, d);
      `CHK("status done", 1'b0, d[0])
      for (int i = 0; i < 3; i++)
      begin
         c[i] = {8'h00, 24'($urandom())};
         wr_reg(5'(4 + 4 * i), c[i]);
      end
      run_mode(acs_pkg::MODE_CONVERT, 24'($urandom()));
      for (int i = 0; i < 3; i++)
      begin
         rd_reg(5'(4 + 4 * i), d);
         `CHK("coeff kept", c[i], d)
      end
      wr_reg(5'h04, 32'h00000000);
      wr_reg(5'h08, 32'h00800000);
      wr_reg(5'h0c, 32'h00800000);
      // Restart a running self calibration with a system offset run
      raw = 24'($urandom());
      wr_reg(5'h00, host.ctl_word(acs_pkg::MODE_SELF_CAL));
      repeat (700) @(posedge i_clk);
      run_mode(acs_pkg::MODE_SYS_OFFSET, raw);
      rd_reg({1'b0, acs_pkg::ADDR_OFFSET}, d);
      `CHK("offset stored", raw, d[23:0])
      run_mode(acs_pkg::MODE_CONVERT, raw);
      `CHK("zero after cal", 1'b1, near(o_result, 24'h800000))
      for (int m = 1; m < 7; m++)
         run_mode(3'(m), 24'($urandom()));
      run_mode(acs_pkg::MODE_RESERVED, 24'($urandom()));
      end_sim();
   end
endmodule // testbench
